/* File: hw/wdm_desc_dma.sv */
/*
 descriptor fetch engine: walks linked tx descriptor lists for ten queue
 units, decodes control words 2-3, assembles fragments, hands frames to
 the paired channel access unit and writes completion status back.
 assumes: host memory is reached by a word fetch/store port answering one
 cycle later; the protocol unit reports completion with done_i.
*/
`timescale 1ns/1ns
// Notes on behaviour
// - ten queue units, each hands frames only to its own access unit
// - tx descriptor is 24 words, rx is 13, all word aligned
// - word 0 is next pointer, low two bits zero, followed by engine
// - word 1 is buffer start; tx any byte, rx word aligned
// - status written to tx words 14-23 or rx words 4-12
// - word 2 bits 11:0 is whole frame length in bytes
// - bit 12 bursts; cts starts protected burst, active burst is protected
// - bit 14 switches rx chain to low power after frame sent
// - bit 15 suppresses retry bit on retried frames
// - bits 21:16 power for series 0 forwarded unchanged
// - bit 22 uses rts/cts, else backoff; bit 31 sends cts first
// - bit 23 ends the list regardless of next pointer
// - bit 24 clears destination mask bit at peer slot
// - bit 29 raises interrupt at frame completion
// - bit 30 qualifies peer slot for key lookup and tracking
// - word 3 bits 11:0 buffer length, nonzero for tx
// - word 3 bit 12 means frame continues in next descriptor
// - bits 19:13 select per-destination entry for key and filtering
// - bits 23:20 frame type, values 5-15 reserved
// - bit 24 means do not wait for acknowledgement
module wdm_desc_dma
	import wdm_pkg::*;
#(
	parameter int NQ = NUM_QUEUES
) (
	// clock and reset
	input  wire logic          clock_i,
	input  wire logic          rst_b_i,
	input  wire logic          ce_i,
	// queue start requests
	input  wire logic [NQ-1:0] q_start_i,
	input  wire logic [31:0]   q_head_i,
	input  wire logic          rx_mode_i,
	// host memory port
	output logic               mem_rd_o,
	output logic               mem_wr_o,
	output logic [31:0]        mem_addr_o,
	output logic [31:0]        mem_wdata_o,
	input  wire logic [31:0]   mem_rdata_i,
	input  wire logic          mem_rvalid_i,
	// frame hand-off
	output logic [NQ-1:0]      cau_ready_o,
	output logic [11:0]        frame_len_o,
	output logic [5:0]         power0_o,
	output logic               rts_o,
	output logic               cts_first_o,
	output logic               burst_prot_o,
	output logic               no_retry_o,
	output logic               no_ack_o,
	output logic [3:0]         ftype_o,
	output logic               slot_valid_o,
	output logic [6:0]         peer_slot_o,
	output logic               clr_mask_o,
	output logic [31:0]        buf_addr_o,
	output logic [11:0]        frag_bytes_o,
	// completion
	input  wire logic          done_i,
	input  wire logic [31:0]   status_i,
	output logic               low_rx_chain_o,
	output logic               irq_o,
	output logic               list_end_o
);
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_FETCH = 3'h1,
		ST_DEC   = 3'h2,
		ST_SEND  = 3'h3,
		ST_WAIT  = 3'h4,
		ST_STAT  = 3'h5,
		ST_NEXT  = 3'h6
	} wdm_state_e;

	wdm_state_e          state;
	logic [31:0]         desc_addr;
	logic [WIDX_W-1:0]   widx;
	logic [WIDX_W-1:0]   nwords;
	logic [WIDX_W-1:0]   st_first;
	logic [WIDX_W-1:0]   st_last;
	logic [$clog2(NQ)-1:0] qsel;
	logic                burst_on;
	logic                frame_irq;
	logic [31:0]         w0;
	logic [31:0]         w1;
	logic [31:0]         w2;
	logic [31:0]         w3;
	wdm_txctl_s          ctl;
	logic                is_rx;
	logic                stop_list;

	wdm_mem_if #(.AW(WIDX_W)) dm ();

	wdm_desc_mem #(.DEPTH(TX_DESC_WORDS), .AW(WIDX_W)) u_mem (
		.clock_i (clock_i),
		.ce_i    (ce_i),
		.port    (dm)
	);

	// decode control words, reserved bits masked away
	function automatic wdm_txctl_s decode(input logic [31:0] a,
	                                      input logic [31:0] b);
		wdm_txctl_s    c;
		logic [31:0]   a2;
		logic [31:0]   b2;
		a2 = a & ~W2_RES_MASK;
		b2 = b & ~W3_RES_MASK;
		c.frame_len  = a2[W2_LEN_HI:0];
		c.burst      = a2[W2_BURST];
		c.low_rx     = a2[W2_LOW_RX];
		c.no_retry   = a2[W2_NO_RETRY];
		c.power0     = a2[W2_PWR_HI:W2_PWR_LO];
		c.rts        = a2[W2_RTS];
		c.cts        = a2[W2_CTS];
		c.end_list   = a2[W2_END_LIST];
		c.clr_mask   = a2[W2_CLR_MASK];
		c.irq        = a2[W2_IRQ];
		c.slot_valid = a2[W2_SLOT_VALID];
		c.buf_len    = b2[W3_LEN_HI:0];
		c.more       = b2[W3_MORE];
		c.peer_slot  = b2[W3_SLOT_HI:W3_SLOT_LO];
		case (b2[W3_TYPE_HI:W3_TYPE_LO])
			FT_NORMAL:   c.ftype = FT_NORMAL;
			FT_ANNOUNCE: c.ftype = FT_ANNOUNCE;
			FT_PS_POLL:  c.ftype = FT_PS_POLL;
			FT_BEACON:   c.ftype = FT_BEACON;
			FT_PROBE:    c.ftype = FT_PROBE;
			default:     c.ftype = FT_RESERVED;
		endcase
		c.no_ack     = b2[W3_NO_ACK];
		c.agg_edge   = b2[W3_AGG_EDGE];
		c.aggregate_member_flag = b2[W3_AGG_MEMBER];
		c.rifs_more  = b2[W3_RIFS_MORE];
		return c;
	endfunction

	assign ctl       = decode(w2, w3);
	assign stop_list = ctl.end_list || (w0 == NULL_PTR);

	// descriptor store port: words land by index, read back as needed
	assign dm.wr_en   = (state == ST_FETCH) && mem_rvalid_i;
	assign dm.wr_addr = widx;
	assign dm.wr_data = mem_rdata_i;
	assign dm.rd_addr = widx;

	// capture the first four words while fetching
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			w0 <= NULL_PTR;
			w1 <= NULL_PTR;
			w2 <= NULL_PTR;
			w3 <= NULL_PTR;
		end else if (ce_i && state == ST_FETCH && mem_rvalid_i) begin
			case (widx)
				5'(LINK_WORD):  w0 <= mem_rdata_i;
				5'(BUF_WORD):   w1 <= mem_rdata_i;
				5'(TX_CTRL_W2): w2 <= mem_rdata_i;
				5'(TX_CTRL_W3): w3 <= mem_rdata_i;
				default:        w0 <= w0;
			endcase
		end
	end

	// main sequencer over the linked list
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			state     <= ST_IDLE;
			desc_addr <= NULL_PTR;
			widx      <= '0;
			qsel      <= '0;
			is_rx     <= 1'b0;
			nwords    <= '0;
			st_first  <= '0;
			st_last   <= '0;
		end else if (ce_i) begin
			case (state)
				ST_IDLE: begin
					if (|q_start_i) begin
						for (int i = NQ - 1; i >= 0; i--) begin
							if (q_start_i[i]) begin
								qsel <= ($clog2(NQ))'(i);
							end
						end
						desc_addr <= {q_head_i[31:2], ALIGN_ZERO};
						is_rx     <= rx_mode_i;
						nwords    <= rx_mode_i ? 5'(RX_DESC_WORDS)
						                       : 5'(TX_DESC_WORDS);
						st_first  <= rx_mode_i ? 5'(RX_STAT_FIRST)
						                       : 5'(TX_STAT_FIRST);
						st_last   <= rx_mode_i ? 5'(RX_STAT_LAST)
						                       : 5'(TX_STAT_LAST);
						widx      <= '0;
						state     <= ST_FETCH;
					end
				end
				ST_FETCH: begin
					if (mem_rvalid_i) begin
						if (widx == st_first - 5'h1) begin
							state <= ST_DEC;
						end else begin
							widx <= widx + 5'h1;
						end
					end
				end
				ST_DEC: begin
					state <= is_rx ? ST_WAIT : ST_SEND;
				end
				ST_SEND: begin
					state <= ST_WAIT;
				end
				ST_WAIT: begin
					if (done_i) begin
						widx  <= st_first;
						state <= ST_STAT;
					end
				end
				ST_STAT: begin
					if (widx == st_last) begin
						state <= ST_NEXT;
					end else begin
						widx <= widx + 5'h1;
					end
				end
				ST_NEXT: begin
					widx <= '0;
					if (stop_list) begin
						state <= ST_IDLE;
					end else begin
						desc_addr <= {w0[31:2], ALIGN_ZERO};
						state     <= ST_FETCH;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// host memory requests: word reads while fetching, status writes
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			mem_rd_o    <= 1'b0;
			mem_wr_o    <= 1'b0;
			mem_addr_o  <= NULL_PTR;
			mem_wdata_o <= NULL_PTR;
		end else if (ce_i) begin
			mem_rd_o    <= (state == ST_FETCH) && !mem_rd_o
			               && !mem_rvalid_i;
			mem_wr_o    <= (state == ST_STAT);
			mem_addr_o  <= desc_addr + {25'h0, widx, ALIGN_ZERO};
			mem_wdata_o <= (state == ST_STAT && widx == st_first)
			               ? status_i : NULL_PTR;
		end
	end

	// burst tracking: protected once started with cts, kept while active
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			burst_on     <= 1'b0;
			burst_prot_o <= 1'b0;
		end else if (ce_i && state == ST_DEC && !is_rx) begin
			if (!ctl.burst) begin
				burst_on     <= 1'b0;
				burst_prot_o <= 1'b0;
			end else if (!burst_on) begin
				burst_on     <= 1'b1;
				burst_prot_o <= ctl.cts;
			end else begin
				burst_prot_o <= 1'b1;
			end
		end
	end

	// frame hand-off to the paired channel access unit
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			cau_ready_o  <= '0;
			frame_len_o  <= LEN_ZERO;
			power0_o     <= '0;
			rts_o        <= 1'b0;
			cts_first_o  <= 1'b0;
			no_retry_o   <= 1'b0;
			no_ack_o     <= 1'b0;
			ftype_o      <= FT_NORMAL;
			slot_valid_o <= 1'b0;
			peer_slot_o  <= '0;
			clr_mask_o   <= 1'b0;
			buf_addr_o   <= NULL_PTR;
			frag_bytes_o <= LEN_ZERO;
		end else if (ce_i) begin
			cau_ready_o <= '0;
			clr_mask_o  <= 1'b0;
			if (state == ST_SEND) begin
				// ready only once the last fragment has been seen
				cau_ready_o[qsel] <= !ctl.more;
				frame_len_o  <= ctl.frame_len;
				power0_o     <= ctl.power0;
				rts_o        <= ctl.rts;
				cts_first_o  <= ctl.cts && !ctl.rts;
				no_retry_o   <= ctl.no_retry;
				no_ack_o     <= ctl.no_ack;
				ftype_o      <= ctl.ftype;
				slot_valid_o <= ctl.slot_valid;
				peer_slot_o  <= ctl.slot_valid ? ctl.peer_slot
				                               : 7'h00;
				clr_mask_o   <= ctl.clr_mask && ctl.slot_valid;
				buf_addr_o   <= w1;
				frag_bytes_o <= ctl.buf_len;
			end
		end
	end

	// completion effects: interrupt, low power rx chain, end of list
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			frame_irq      <= 1'b0;
			irq_o          <= 1'b0;
			low_rx_chain_o <= 1'b0;
			list_end_o     <= 1'b0;
		end else if (ce_i) begin
			irq_o      <= 1'b0;
			list_end_o <= 1'b0;
			if (state == ST_DEC) begin
				frame_irq <= ctl.irq;
			end
			if (state == ST_NEXT) begin
				irq_o      <= frame_irq && !ctl.more;
				list_end_o <= stop_list;
				if (!is_rx && !ctl.more) begin
					low_rx_chain_o <= ctl.low_rx;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_ready_single: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		$onehot0(cau_ready_o)) else $error("two units ready");
	a_cts_excl: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		!(rts_o && cts_first_o)) else $error("rts and cts both");
	a_addr_align: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		mem_rd_o |-> mem_addr_o[1:0] == ALIGN_ZERO)
		else $error("unaligned fetch");
	a_fetch_bound: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		mem_rd_o |-> $past(widx) < nwords) else $error("fetch past end");
	a_stat_range: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		mem_wr_o |-> $past(widx) >= $past(st_first) &&
		$past(widx) <= $past(st_last)) else $error("status off range");
	a_end_stop: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		ce_i && state == ST_NEXT && stop_list |=> state == ST_IDLE)
		else $error("list not ended");
	a_clr_valid: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		clr_mask_o |-> slot_valid_o) else $error("mask clear no slot");
	a_irq_frame: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		irq_o |-> $past(frame_irq)) else $error("stray interrupt");
	a_power_pass: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		ce_i && state == ST_SEND |=> power0_o == $past(w2[W2_PWR_HI:W2_PWR_LO]))
		else $error("power altered");
	a_frag_hold: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		ce_i && state == ST_SEND && ctl.more |=> cau_ready_o == '0)
		else $error("fragment handed early");
	c_frame_sent: cover property (@(posedge clock_i) |cau_ready_o);
	c_burst_prot: cover property (@(posedge clock_i) burst_prot_o);
	c_irq_seen: cover property (@(posedge clock_i) irq_o);
	c_list_end: cover property (@(posedge clock_i) list_end_o);
endmodule

/* File: hw/wdm_desc_mem.sv */
/*
 small word store holding one fetched descriptor; registered read data.
 assumes: single clock, clock enable freezes all state.
*/
`timescale 1ns/1ns
module wdm_desc_mem #(
	parameter int DEPTH = 24,
	parameter int AW    = 5
) (
	// clock
	input  wire logic clock_i,
	input  wire logic ce_i,
	// port
	wdm_mem_if.mem    port
);
	logic [31:0] store [DEPTH];
	logic [31:0] rd_q;

	// write and registered read
	always_ff @(posedge clock_i) begin
		if (ce_i) begin
			if (port.wr_en) begin
				store[port.wr_addr] <= port.wr_data;
			end
			rd_q <= store[port.rd_addr];
		end
	end
	assign port.rd_data = rd_q;
endmodule

/* File: hw/wdm_mem_if.sv */
/*
 interface carrying the descriptor word store port.
 assumes: one clock; read data one cycle after the read request.
*/
`timescale 1ns/1ns
interface wdm_mem_if #(
	parameter int AW = 5
);
	logic          wr_en;
	logic [AW-1:0] wr_addr;
	logic [31:0]   wr_data;
	logic [AW-1:0] rd_addr;
	logic [31:0]   rd_data;

	modport ctrl (output wr_en, output wr_addr, output wr_data,
	              output rd_addr, input rd_data);
	modport mem  (input wr_en, input wr_addr, input wr_data,
	              input rd_addr, output rd_data);
endinterface

/* File: hw/wdm_pkg.sv */
/*
 package for the descriptor dma front end: descriptor geometry, control
 word field positions, frame types, queue counts.
 assumes: included before every other design file.
*/
package wdm_pkg;

	// descriptor geometry
	localparam int TX_DESC_WORDS  = 24;
	localparam int RX_DESC_WORDS  = 13;
	localparam int TX_STAT_FIRST  = 14;
	localparam int TX_STAT_LAST   = 23;
	localparam int RX_STAT_FIRST  = 4;
	localparam int RX_STAT_LAST   = 12;
	localparam int TX_CTRL_W2     = 2;
	localparam int TX_CTRL_W3     = 3;
	localparam int LINK_WORD      = 0;
	localparam int BUF_WORD       = 1;
	localparam int NUM_QUEUES     = 10;
	localparam int WIDX_W         = 5;

	// word 2 fields
	localparam int W2_LEN_HI      = 11;
	localparam int W2_BURST       = 12;
	localparam int W2_LOW_RX      = 14;
	localparam int W2_NO_RETRY    = 15;
	localparam int W2_PWR_LO      = 16;
	localparam int W2_PWR_HI      = 21;
	localparam int W2_RTS         = 22;
	localparam int W2_END_LIST    = 23;
	localparam int W2_CLR_MASK    = 24;
	localparam int W2_IRQ         = 29;
	localparam int W2_SLOT_VALID  = 30;
	localparam int W2_CTS         = 31;

	// word 3 fields
	localparam int W3_LEN_HI      = 11;
	localparam int W3_MORE        = 12;
	localparam int W3_SLOT_LO     = 13;
	localparam int W3_SLOT_HI     = 19;
	localparam int W3_TYPE_LO     = 20;
	localparam int W3_TYPE_HI     = 23;
	localparam int W3_NO_ACK      = 24;
	localparam int W3_AGG_EDGE    = 29;
	localparam int W3_AGG_MEMBER  = 30;
	localparam int W3_RIFS_MORE   = 31;

	// reserved masks: word 2 bits 28:25 and 13, word 3 bits 28:25
	localparam logic [31:0] W2_RES_MASK = 32'h1e00_2000;
	localparam logic [31:0] W3_RES_MASK = 32'h1e00_0000;
	localparam logic [1:0]  ALIGN_ZERO  = 2'h0;
	localparam logic [31:0] NULL_PTR    = 32'h0000_0000;
	localparam logic [11:0] LEN_ZERO    = 12'h000;

	// frame types
	typedef enum logic [3:0] {
		FT_NORMAL   = 4'h0,
		FT_ANNOUNCE = 4'h1,
		FT_PS_POLL  = 4'h2,
		FT_BEACON   = 4'h3,
		FT_PROBE    = 4'h4,
		FT_RESERVED = 4'hf
	} wdm_ftype_e;

	// decoded transmit controls
	typedef struct packed {
		logic [11:0] frame_len;
		logic        burst;
		logic        low_rx;
		logic        no_retry;
		logic [5:0]  power0;
		logic        rts;
		logic        cts;
		logic        end_list;
		logic        clr_mask;
		logic        irq;
		logic        slot_valid;
		logic [11:0] buf_len;
		logic        more;
		logic [6:0]  peer_slot;
		wdm_ftype_e  ftype;
		logic        no_ack;
		logic        agg_edge;
		logic        aggregate_member_flag;
		logic        rifs_more;
	} wdm_txctl_s;

endpackage

/* File: testbench/wdm_desc_dma_bench.sv */
/*
 self-checking bench for the descriptor fetch engine.
 assumes: host memory model answers the word port; done_i held high
 so every frame completes as soon as the engine waits for it.
*/
`timescale 1ns/1ns
module wdm_desc_dma_bench;
	import wdm_pkg::*;
	localparam logic [31:0] STAT = 32'h0000_c0de;
	logic        clock_i, rst_b_i, ce_i, rx_mode_i, done_i;
	logic [9:0]  q_start_i, cau_ready_o, last_rdy;
	logic [31:0] q_head_i, status_i, mem_addr_o, mem_wdata_o, mem_rdata_i;
	logic [31:0] buf_addr_o, first_rd, w2, w3;
	logic        mem_rd_o, mem_wr_o, mem_rvalid_i, rts_o, cts_first_o;
	logic        burst_prot_o, no_retry_o, no_ack_o, slot_valid_o;
	logic        clr_mask_o, low_rx_chain_o, irq_o, list_end_o;
	logic [11:0] frame_len_o, frag_bytes_o;
	logic [5:0]  power0_o;
	logic [3:0]  ftype_o;
	logic [6:0]  peer_slot_o;
	logic [1:0]  rdy_d;
	logic [78:0] snap [0:3];
	int          n_fail, num_checks, n_rd, n_rdy, n_irq, n_clr;

	wdm_desc_dma dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
		.q_start_i(q_start_i), .q_head_i(q_head_i), .rx_mode_i(rx_mode_i),
		.mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_addr_o(mem_addr_o),
		.mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i),
		.mem_rvalid_i(mem_rvalid_i), .cau_ready_o(cau_ready_o),
		.frame_len_o(frame_len_o), .power0_o(power0_o), .rts_o(rts_o),
		.cts_first_o(cts_first_o), .burst_prot_o(burst_prot_o),
		.no_retry_o(no_retry_o), .no_ack_o(no_ack_o), .ftype_o(ftype_o),
		.slot_valid_o(slot_valid_o), .peer_slot_o(peer_slot_o),
		.clr_mask_o(clr_mask_o), .buf_addr_o(buf_addr_o),
		.frag_bytes_o(frag_bytes_o), .done_i(done_i), .status_i(status_i),
		.low_rx_chain_o(low_rx_chain_o), .irq_o(irq_o),
		.list_end_o(list_end_o));

	wdm_host_mem mem (.clock_i(clock_i), .rd_i(mem_rd_o), .wr_i(mem_wr_o),
		.addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i),
		.rvalid_o(mem_rvalid_i));

	// -----------------------------------------------------------------
	// monitor: count pulses, snapshot frame fields after each hand-off
	// -----------------------------------------------------------------
	always @(posedge clock_i) begin
		rdy_d <= {rdy_d[0], |cau_ready_o};
		if (cau_ready_o !== 10'h000) begin
			n_rdy    <= n_rdy + 1;
			last_rdy <= cau_ready_o;
		end
		if (rdy_d[1] === 1'b1) begin
			snap[n_rdy-1] <= {frame_len_o, power0_o, rts_o, cts_first_o,
				burst_prot_o, no_retry_o, no_ack_o, ftype_o, slot_valid_o,
				peer_slot_o, buf_addr_o, frag_bytes_o};
		end
		if (mem_rd_o === 1'b1 && n_rd == 0) first_rd <= mem_addr_o;
		if (mem_rd_o === 1'b1) n_rd <= n_rd + 1;
		if (irq_o === 1'b1) n_irq <= n_irq + 1;
		if (clr_mask_o === 1'b1) n_clr <= n_clr + 1;
	end

	initial begin
		clock_i = 1'b0;
		forever #4 clock_i = ~clock_i;
	end

	// -----------------------------------------------------------------
	// helpers
	// -----------------------------------------------------------------
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic check_word(string nm, logic [31:0] e, logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic check_ctl(logic [78:0] e, logic [78:0] g);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED controls expected %h seen %h", e, g);
		end
	endtask

	// expected hand-off fields from the descriptor words
	function automatic logic [78:0] exp_ctl(logic [31:0] b, logic [31:0] c2,
			logic [31:0] c3, logic prot);
		logic [3:0] ft;
		logic [6:0] ps;
		ft = (c3[23:20] > 4'h4) ? 4'hf : c3[23:20];
		ps = c2[30] ? c3[19:13] : 7'h00;
		return {c2[11:0], c2[21:16], c2[22], c2[31] & ~c2[22], prot,
			c2[15], c3[24], ft, c2[30], ps, b, c3[11:0]};
	endfunction

	// descriptor in host memory; status words preset to all ones
	task automatic put_desc(logic [31:0] base, logic [31:0] link,
			logic [31:0] b, logic [31:0] c2, logic [31:0] c3);
		for (int i = 0; i < TX_DESC_WORDS; i++) begin
			mem.words[base[10:2]+i] = 32'hffff_ffff;
		end
		mem.words[base[10:2]]   = link;
		mem.words[base[10:2]+1] = b;
		mem.words[base[10:2]+2] = c2;
		mem.words[base[10:2]+3] = c3;
	endtask

	task automatic check_status(logic [31:0] base, int first, int last);
		for (int i = first; i <= last; i++) begin
			check_word("status", (i == first) ? STAT : 32'h0,
				mem.words[base[10:2]+i]);
		end
	endtask

	// start a list and wait, bounded, for its end pulse
	task automatic run(logic [9:0] qm, logic [31:0] head, logic rx);
		int k;
		n_rd = 0;
		n_rdy = 0;
		n_irq = 0;
		n_clr = 0;
		last_rdy = 10'h000;
		q_start_i <= qm;
		q_head_i  <= head;
		rx_mode_i <= rx;
		for (k = 0; k < 3000; k++) begin
			@(posedge clock_i);
			if (mem_rd_o === 1'b1) q_start_i <= 10'h000;
			if (list_end_o === 1'b1) break;
		end
		if (k == 3000) begin
			n_fail++;
			tally_and_finish();
		end else begin
			repeat (3) @(posedge clock_i);
		end
	endtask

	// -----------------------------------------------------------------
	// main sequence
	// -----------------------------------------------------------------
	initial begin
		rst_b_i = 1'b0; ce_i = 1'b1; rx_mode_i = 1'b0; done_i = 1'b0;
		q_start_i = 10'h000; q_head_i = 32'h0; status_i = STAT;
		n_fail = 0; num_checks = 0; n_rd = 0; n_rdy = 0; n_irq = 0;
		n_clr = 0; rdy_d = 2'b00;
		repeat (3) @(posedge clock_i);
		rst_b_i <= 1'b1;
		done_i  <= 1'b1;
		@(posedge clock_i);
		// every queue, one single-descriptor frame each
		for (int q = 0; q < NUM_QUEUES; q++) begin
			w2 = 32'h0000_00a0 + q;
			w2[21:16] = 6'(q * 5);
			w2[22] = (q == 1);
			w2[31] = (q == 2);
			w2[29] = q[0];
			w2[24] = (q % 3 == 0);
			w2[30] = (q % 3 == 0);
			w2[15] = q[1];
			w3 = 32'h0000_0040 + q;
			w3[19:13] = 7'h55;
			w3[23:20] = (q == 9) ? 4'hf : 4'(q % 6);
			w3[24] = q[0];
			w3[30] = q[2];
			if (q == 4) begin
				w2 = w2 | W2_RES_MASK;
				w3 = w3 | W3_RES_MASK;
			end
			put_desc(32'h100, NULL_PTR, 32'h1000_0001 + q, w2, w3);
			run(10'(1 << q), 32'h100, 1'b0);
			check_word("ready", 32'(1 << q), 32'(last_rdy));
			check_word("nready", 1, n_rdy);
			check_word("reads", TX_DESC_WORDS - 10, n_rd);
			check_word("head", 32'h100, first_rd);
			check_word("irq", 32'(w2[29]), n_irq);
			check_word("clr", 32'(w2[24] & w2[30]), n_clr);
			check_ctl(exp_ctl(32'h1000_0001 + q, w2, w3, 1'b0),
				snap[0]);
			check_status(32'h100, TX_STAT_FIRST, TX_STAT_LAST);
		end
		// two queues asking at once: lowest index served alone
		run(10'h088, 32'h100, 1'b0);
		check_word("lowest", 32'h008, 32'(last_rdy));
		// two fragments; end mark stops despite a non-null link
		put_desc(32'h200, 32'h300, 32'h2000, 32'h2000_0040,
			32'h0000_1020);
		put_desc(32'h300, 32'h400, 32'h3000, 32'h2080_0040,
			32'h0000_0020);
		put_desc(32'h400, NULL_PTR, 32'h4000, 32'h0000_0040, 32'h20);
		run(10'h020, 32'h200, 1'b0);
		check_word("nready", 1, n_rdy);
		check_word("reads", 28, n_rd);
		check_word("irq", 1, n_irq);
		check_status(32'h300, TX_STAT_FIRST, TX_STAT_LAST);
		// burst: protected start by cts, then stays protected
		check_word("lowrx", 32'h0, 32'(low_rx_chain_o));
		put_desc(32'h500, 32'h600, 32'h5000, 32'h8000_1050, 32'h30);
		put_desc(32'h600, NULL_PTR, 32'h6000, 32'h0000_5050, 32'h30);
		run(10'h001, 32'h500, 1'b0);
		check_word("nready", 2, n_rdy);
		check_ctl(exp_ctl(32'h5000, 32'h8000_1050, 32'h30, 1'b1),
			snap[0]);
		check_ctl(exp_ctl(32'h6000, 32'h0000_5050, 32'h30, 1'b1),
			snap[1]);
		check_word("lowrx", 32'h1, 32'(low_rx_chain_o));
		// receive descriptor: four words fetched, status in 4 to 12
		put_desc(32'h700, NULL_PTR, 32'h7000, 32'h0, 32'h0000_0100);
		run(10'h002, 32'h700, 1'b1);
		check_word("reads", RX_STAT_FIRST, n_rd);
		check_word("nready", 0, n_rdy);
		check_status(32'h700, RX_STAT_FIRST, RX_STAT_LAST);
		check_word("rxtail", 32'hffff_ffff,
			mem.words[(32'h700 >> 2) + RX_DESC_WORDS]);
		tally_and_finish();
	end
endmodule

/* File: testbench/wdm_host_mem.sv */
/*
 host memory model: word store behind the descriptor fetch/store port.
 assumes: one clock shared with the engine; a read is answered one
 cycle later; between answers the data lines do not hold old values.
*/
`timescale 1ns/1ns
module wdm_host_mem (
	// clock
	input  wire logic        clock_i,
	// request
	input  wire logic        rd_i,
	input  wire logic        wr_i,
	input  wire logic [31:0] addr_i,
	input  wire logic [31:0] wdata_i,
	// answer
	output logic [31:0]      rdata_o,
	output logic             rvalid_o
);
	logic [31:0] words [0:511];

	initial begin
		rdata_o  = 32'h0000_0000;
		rvalid_o = 1'b0;
	end

	// -----------------------------------------------------------------
	// word port
	// -----------------------------------------------------------------
	// word addressed only, low address bits dropped; data scrambled
	always @(posedge clock_i) begin
		rvalid_o <= rd_i;
		rdata_o  <= rd_i ? words[addr_i[10:2]] : ~rdata_o;
		if (wr_i) begin
			words[addr_i[10:2]] <= wdata_i;
		end
	end
endmodule
